// *** pwr_mode_cfg.svh ***
`ifndef PWR_MODE_CFG_SVH
`define PWR_MODE_CFG_SVH
`define CTRL_IDX       4'h1
`define STATUS_IDX     4'h2
`define CTRL_MIRROR_B  0
`define CTRL_ILLUM_B   1
`define CTRL_RESET     2'h0
`define FAULT_SRC_W    5
`endif

// *** pwr_mode_pkg.sv ***
package pwr_mode_pkg;
  typedef enum logic [4:0] {
    ST_OFF     = 5'h01,
    ST_IDLE    = 5'h02,
    ST_STANDBY = 5'h04,
    ST_MIRROR  = 5'h08,
    ST_FULL    = 5'h10
  } mode_e;
  typedef struct packed {
    logic power_good_fault;
    logic over_voltage_fault;
    logic thermal_shutdown;
    logic undervoltage_lockout;
    logic supply_undervoltage;
  } fault_s;
  typedef struct packed {
    logic mirror_reset_rail;
    logic mirror_bias_rail;
    logic mirror_offset_rail;
    logic led_supply_enable;
    logic core_regulator_enable;
    logic system_reset_n;
  } rails_s;
endpackage

// *** fault_merge.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pwr_mode_cfg.svh"
module fault_merge (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire pwr_mode_pkg::fault_s faults_i,
  output logic                      fault_o
);
  wire any_fault = |faults_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_o <= 1'b0;
    end else begin
      fault_o <= any_fault;
    end
  end
endmodule
`default_nettype wire

// *** projector_power_mode_fsm.sv ***
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "pwr_mode_cfg.svh"
module projector_power_mode_fsm (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 projector_power_request_i,
  input  wire pwr_mode_pkg::fault_s faults_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [3:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  output pwr_mode_pkg::rails_s      rails_o,
  output logic      [4:0]           mode_o
);
  pwr_mode_pkg::mode_e state_r;
  pwr_mode_pkg::mode_e state_nxt;
  logic                req_d_r;
  logic                mirror_en_r;
  logic                illumination_enable_r;
  logic                fault;

  fault_merge u_fault (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .faults_i (faults_i),
    .fault_o  (fault)
  );

  // Word index on a byte address bus: adr[3:2]
  wire       req       = projector_power_request_i;
  wire       req_rise  = req & ~req_d_r;
  wire [3:0] word_idx  = {2'h0, wb_adr_i[3:2]};
  wire       bus_on    = req && state_r != pwr_mode_pkg::ST_OFF;
  wire       access    = wb_cyc_i & wb_stb_i & ~wb_ack_o & bus_on;
  wire       hit_ctrl  = word_idx == `CTRL_IDX;
  wire       hit_stat  = word_idx == `STATUS_IDX;
  wire       wr_ctrl   = access & wb_we_i & hit_ctrl & wb_sel_i[0];
  wire [31:0] rd_data  = hit_ctrl ? {30'h0, illumination_enable_r, mirror_en_r} :
                         hit_stat ? {26'h0, fault, state_r} : 32'h0;

  always_comb begin
    state_nxt = state_r;
    if (!req) begin
      state_nxt = pwr_mode_pkg::ST_OFF;
    end else begin
      unique case (state_r)
        pwr_mode_pkg::ST_OFF: begin
          state_nxt = pwr_mode_pkg::ST_IDLE;
        end
        pwr_mode_pkg::ST_STANDBY: begin
          if (!fault) state_nxt = pwr_mode_pkg::ST_IDLE;
        end
        default: begin
          if (fault) state_nxt = pwr_mode_pkg::ST_STANDBY;
          else if (!mirror_en_r) state_nxt = pwr_mode_pkg::ST_IDLE;
          else if (illumination_enable_r) state_nxt = pwr_mode_pkg::ST_FULL;
          else state_nxt = pwr_mode_pkg::ST_MIRROR;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= pwr_mode_pkg::ST_OFF;
      req_d_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      req_d_r <= req;
    end
  end

  // Off clears both bits; fault or request rise clears mirror_en_r, but a control write still loads illumination_enable_r
  always_ff @(posedge clk_i) begin
    if (rst_i || !req) begin
      mirror_en_r <= `CTRL_RESET >> 0 != 0;
      illumination_enable_r  <= 1'b0;
    end else if (req_rise || fault) begin
      mirror_en_r <= 1'b0;
      if (wr_ctrl) illumination_enable_r <= wb_dat_i[`CTRL_ILLUM_B];
    end else if (wr_ctrl) begin
      mirror_en_r <= wb_dat_i[`CTRL_MIRROR_B];
      illumination_enable_r  <= wb_dat_i[`CTRL_ILLUM_B];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= access;
      wb_dat_o <= access ? rd_data : 32'h0;
    end
  end

  wire mirror_on = state_nxt == pwr_mode_pkg::ST_MIRROR || state_nxt == pwr_mode_pkg::ST_FULL;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rails_o <= '0;
      mode_o  <= 5'h01;
    end else begin
      rails_o.mirror_reset_rail     <= mirror_on;
      rails_o.mirror_bias_rail      <= mirror_on;
      rails_o.mirror_offset_rail    <= mirror_on;
      rails_o.led_supply_enable     <= state_nxt == pwr_mode_pkg::ST_FULL;
      rails_o.core_regulator_enable <= state_nxt != pwr_mode_pkg::ST_OFF;
      rails_o.system_reset_n        <= state_nxt != pwr_mode_pkg::ST_OFF &&
                                       state_nxt != pwr_mode_pkg::ST_STANDBY;
      mode_o                        <= state_nxt;
    end
  end
endmodule
`default_nettype wire

// *** pwr_mode_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module pwr_mode_props (
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 projector_power_request_i,
  input wire pwr_mode_pkg::fault_s faults_i,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_ack_o,
  input wire pwr_mode_pkg::rails_s rails_o,
  input wire logic [4:0]           mode_o
);
  wire rq  = projector_power_request_i;
  wire off = mode_o == pwr_mode_pkg::ST_OFF;
  wire sb  = mode_o == pwr_mode_pkg::ST_STANDBY;
  wire m   = rails_o.mirror_reset_rail;
  wire l   = rails_o.led_supply_enable;
  wire s   = rails_o.system_reset_n;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Fault is registered, so allow slack before the mode moves
  sequence s_flt; (rq && |faults_i) [*4]; endsequence
  AST_OFF: assert property (!rq |=> off && rails_o == '0 && !wb_ack_o)
    else $error("not off");
  AST_CORE: assert property (rails_o.core_regulator_enable == !off)
    else $error("core enable");
  AST_FLT: assert property (s_flt |-> sb)
    else $error("no standby");
  AST_STBY: assert property (sb |-> !m && !l && !s)
    else $error("standby rails");
  AST_LEAVE: assert property ($past(sb) && !sb |-> mode_o inside {pwr_mode_pkg::ST_IDLE, pwr_mode_pkg::ST_OFF})
    else $error("bad exit");
  AST_IDLE: assert property (mode_o == pwr_mode_pkg::ST_IDLE |-> !m && !l && s)
    else $error("idle rails");
  AST_MIR: assert property (mode_o == pwr_mode_pkg::ST_MIRROR |-> m && rails_o.mirror_bias_rail && !l && s)
    else $error("mirror rails");
  AST_FULL: assert property (mode_o == pwr_mode_pkg::ST_FULL |-> m && l && s)
    else $error("full rails");
  AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && rq && !off |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack");
endmodule
`default_nettype wire

// *** display_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module display_ctrl_model (
  input  wire logic clk_i,
  input  wire logic want_on_i,
  output logic      request_o
);
  // Low request or rst_i is the only way below standby power
  always_ff @(posedge clk_i) begin
    request_o <= want_on_i;
  end
endmodule
`default_nettype wire

// *** projector_power_mode_fsm_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module projector_power_mode_fsm_tb_top;
  logic                 clk_i = 0, rst_i = 1, on = 0, cyc = 0, we = 0, rq, ack;
  logic [3:0]           adr = 0, sel = 4'hf;
  logic [31:0]          wd = 0, rd, q;
  logic [4:0]           mode;
  pwr_mode_pkg::fault_s flt = '0;
  pwr_mode_pkg::rails_s rails;
  int                   fail_count = 0, cmp_count = 0;
  always #5 clk_i = ~clk_i;
  display_ctrl_model ctl (.clk_i(clk_i), .want_on_i(on), .request_o(rq));
  projector_power_mode_fsm uut (.clk_i(clk_i), .rst_i(rst_i), .projector_power_request_i(rq), .faults_i(flt),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
    .wb_dat_o(rd), .wb_ack_o(ack), .rails_o(rails), .mode_o(mode));
  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1; we <= w; adr <= a; wd <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rd;
    cyc <= 0;
  endtask
  task automatic t_up;
    chk(rails, 0);
    chk(mode, 5'h01);
    on <= 1;
    wb(0, 4'h4, 0);
    chk(q, 0);
    wb(0, 4'h8, 0);
    chk(q, 32'h02);
    chk(rails.core_regulator_enable, 1);
  endtask
  task automatic t_modes;
    logic [31:0] w [3] = '{32'h1, 32'h3, 32'h2};
    logic [31:0] e [3] = '{32'h08, 32'h10, 32'h02};
    for (int i = 0; i < 3; i++) begin
      wb(1, 4'h4, w[i]);
      wb(0, 4'h8, 0);
      chk(q, e[i]);
    end
    wb(1, 4'hc, 32'hff);
    wb(0, 4'hc, 0);
    chk(q, 0);
    // Control write without byte lane 0 must leave the mode alone
    sel <= 4'h0;
    wb(1, 4'h4, 32'h1);
    sel <= 4'hf;
    wb(0, 4'h8, 0);
    chk(q, 32'h02);
  endtask
  task automatic t_fault;
    for (int i = 0; i < 5; i++) begin
      wb(1, 4'h4, 32'h3);
      flt <= pwr_mode_pkg::fault_s'(5'h01 << i);
      repeat (3) @(posedge clk_i);
      wb(0, 4'h8, 0);
      chk(q, 32'h24);
      chk(rails.system_reset_n, 0);
      flt <= '0;
      repeat (3) @(posedge clk_i);
      wb(0, 4'h8, 0);
      chk(q, 32'h02);
      wb(0, 4'h4, 0);
      chk(q, 32'h2);
    end
  endtask
  task automatic t_down;
    wb(1, 4'h4, 32'h3);
    on <= 0;
    repeat (3) @(posedge clk_i);
    chk(mode, 5'h01);
    chk(rails, 0);
    on <= 1;
    wb(0, 4'h4, 0);
    chk(q, 0);
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    t_up();
    t_modes();
    t_fault();
    t_down();
    finish_test();
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    fail_count++;
    finish_test();
  end
endmodule
bind projector_power_mode_fsm pwr_mode_props props (.*);
`default_nettype wire
